// File: dsw_master_model.sv
// behavioural fieldbus master writing the speed reference word
`timescale 1ns/1ps
module dsw_master_model (
   input wire ref_clk,
   input wire send,
   input wire [15:0] word,
   output reg ref_write = 1'b0,
   output reg [15:0] ref_word_in = 16'h0000
);
   // whole word per write; idle data toggles so a stale word never looks valid
   always @(negedge ref_clk) begin
      ref_write <= send;
      ref_word_in <= send ? word : ~ref_word_in;
   end
endmodule // dsw_master_model

// File: dsw_monitor.sv
// port-level checker for the drive status and speed word block
`timescale 1ns/1ps
module dsw_monitor #(
   parameter FREQ_WIDTH = 16
) (
   // clock and reset
   input wire ref_clk, sys_rst,
   // watched inputs
   input wire tripped, trip_locked, warning_any, ref_write,
   input wire [15:0] ref_word_in,
   input wire [FREQ_WIDTH-1:0] out_freq, ref_freq,
   // watched outputs
   input wire [15:0] drive_status_word, speed_reference_q, speed_reference_pct_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // cycles since reset, so $past never looks back into reset
   reg [2:0] up_q = 3'h0;
   always @(posedge ref_clk) up_q <= sys_rst ? 3'h0 : up_q + {2'h0, ~up_q[2]};
   property p_unused; drive_status_word[5] == 1'b0; endproperty
   a_unused: assert property (p_unused) else $error("unused status bit set");
   property p_trip; up_q[2] |-> drive_status_word[3] == $past(tripped, 3); endproperty
   a_trip: assert property (p_trip) else $error("trip bit wrong");
   property p_ready; up_q[2] && $past(tripped, 3) |-> !drive_status_word[0]; endproperty
   a_ready: assert property (p_ready) else $error("ready bit high on trip");
   property p_lock; up_q[2] && $past(tripped, 3) && $past(trip_locked, 3) |-> drive_status_word[6]; endproperty
   a_lock: assert property (p_lock) else $error("lock bit low");
   property p_warn; up_q[2] |-> drive_status_word[7] == $past(warning_any, 3); endproperty
   a_warn: assert property (p_warn) else $error("warning bit wrong");
   property p_onref; up_q[2] |-> drive_status_word[8] == ($past(out_freq) == $past(ref_freq)); endproperty
   a_onref: assert property (p_onref) else $error("on-reference bit wrong");
   property p_ref; ref_write |=> speed_reference_q == $past(ref_word_in); endproperty
   a_ref: assert property (p_ref) else $error("reference not captured");
   property p_pct; ref_write && ref_word_in == 16'h4000 |=> speed_reference_pct_q == 16'h2710; endproperty
   a_pct: assert property (p_pct) else $error("full scale not 100 percent");
endmodule // dsw_monitor
bind dsw_status_top dsw_monitor #(.FREQ_WIDTH(FREQ_WIDTH)) u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .tripped(tripped), .trip_locked(trip_locked), .warning_any(warning_any), .ref_write(ref_write),
   .ref_word_in(ref_word_in), .out_freq(out_freq), .ref_freq(ref_freq), .drive_status_word(drive_status_word),
   .speed_reference_q(speed_reference_q), .speed_reference_pct_q(speed_reference_pct_q));

// File: dsw_regs.vh
// bit positions, scaling constants and codes for the drive status and speed words
`ifndef DSW_REGS_VH
`define DSW_REGS_VH
`define DSW_BIT_CTRL_READY 4'h0
`define DSW_BIT_DRV_READY 4'h1
`define DSW_BIT_ENABLE 4'h2
`define DSW_BIT_TRIP 4'h3
`define DSW_BIT_ERROR 4'h4
`define DSW_BIT_UNUSED 4'h5
`define DSW_BIT_TRIPLOCK 4'h6
`define DSW_BIT_WARNING 4'h7
`define DSW_BIT_ON_REF 4'h8
`define DSW_BIT_BUS_CTRL 4'h9
`define DSW_BIT_FREQ_OK 4'ha
`define DSW_BIT_RUNNING 4'hb
`define DSW_BIT_AUTO_RESTART 4'hc
`define DSW_BIT_VOLTAGE 4'hd
`define DSW_BIT_CURRENT 4'he
`define DSW_BIT_TIMER 4'hf
`define DSW_STATUS_RESET 16'h0000
`define DSW_FULL_SCALE 16'h4000
`define DSW_ZERO_WORD 16'h0000
`define DSW_TIMER_FULL 16'h4000
`endif

// File: dsw_scale.v
// converts a signed raw value to a percent-scaled word relative to a full-scale magnitude
`timescale 1ns/1ps
`include "dsw_regs.vh"
module dsw_scale #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // raw signed frequency and full-scale frequency
   input wire [WIDTH-1:0] raw_value,
   input wire [WIDTH-1:0] full_scale,
   // percent-scaled two's complement word
   output reg [15:0] scaled_word
);
   reg signed [WIDTH+15:0] prod;
   reg signed [WIDTH+15:0] quot;

   // raw * 0x4000 / full_scale, registered; zero full scale gives zero
   always @* begin
      prod = $signed(raw_value) * $signed({1'b0, `DSW_FULL_SCALE});
      if (full_scale == {WIDTH{1'b0}})
         quot = {(WIDTH+16){1'b0}};
      else
         quot = prod / $signed({1'b0, full_scale});
   end

   always @(posedge ref_clk) begin
      if (sys_rst)
         scaled_word <= `DSW_ZERO_WORD;
      else
         scaled_word <= quot[15:0];
   end
endmodule // dsw_scale

// File: dsw_status_top.v
// drive status word builder with speed reference capture and actual frequency word
`timescale 1ns/1ps
`include "dsw_regs.vh"
module dsw_status_top #(
   parameter FREQ_WIDTH = 16
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // asynchronous drive conditions
   input wire tripped,
   input wire trip_locked,
   input wire controls_ready,
   input wire power_ready,
   input wire coast_active,
   input wire start_active,
   input wire error_no_trip,
   input wire warning_any,
   input wire local_forced,
   input wire overtemp_hold,
   input wire dc_link_low,
   input wire dc_link_high,
   // drive internal values, same clock
   input wire [FREQ_WIDTH-1:0] out_freq,
   input wire [FREQ_WIDTH-1:0] ref_freq,
   input wire [FREQ_WIDTH-1:0] freq_low_limit,
   input wire [FREQ_WIDTH-1:0] freq_high_limit,
   input wire [FREQ_WIDTH-1:0] freq_full_scale,
   input wire [15:0] motor_current,
   input wire [15:0] current_limit,
   input wire [15:0] motor_thermal_timer,
   input wire [15:0] drive_thermal_timer,
   // speed reference from the master
   input wire ref_write,
   input wire [15:0] ref_word_in,
   // words read by the master
   output reg [15:0] drive_status_word,
   output reg [15:0] actual_output_frequency_word,
   output reg [15:0] speed_reference_q,
   output reg [15:0] speed_reference_pct_q
);
   localparam NCOND = 12;
   wire [NCOND-1:0] cond_raw;
   wire [NCOND-1:0] cond_s;
   wire [15:0] mav_word;
   reg [15:0] status_d;

   // signed two's complement value of a percent word in units of 0.01 percent
   function [15:0] dsw_to_centi;
      input [15:0] w;
      reg signed [31:0] p;
      begin
         p = $signed(w) * $signed(32'sd10000);
         dsw_to_centi = p[29:14];
      end
   endfunction

   // strict above-limit test shared by the current bit and both timer checks
   function dsw_above;
      input [15:0] value;
      input [15:0] limit;
      begin
         dsw_above = (value > limit);
      end
   endfunction

   assign cond_raw = {dc_link_high, dc_link_low, overtemp_hold, local_forced, warning_any,
                      error_no_trip, start_active, coast_active, power_ready, controls_ready,
                      trip_locked, tripped};

   // pin-level conditions cross from the power section asynchronously
   dsw_sync2 #(
      .WIDTH(NCOND)
   ) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in(cond_raw),
      .sync_out(cond_s)
   );

   // actual frequency expressed as signed percent word
   dsw_scale #(
      .WIDTH(FREQ_WIDTH)
   ) u_scale (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .raw_value(out_freq),
      .full_scale(freq_full_scale),
      .scaled_word(mav_word)
   );

   wire s_trip = cond_s[0];
   wire s_lock = cond_s[1];
   wire s_ctrl = cond_s[2];
   wire s_pwr = cond_s[3];
   wire s_coast = cond_s[4];
   wire s_start = cond_s[5];
   wire s_err = cond_s[6];
   wire s_warn = cond_s[7];
   wire s_local = cond_s[8];
   wire s_otemp = cond_s[9];
   wire s_vlow = cond_s[10];
   wire s_vhigh = cond_s[11];

   // every bit recomputed from present conditions each cycle
   always @* begin
      status_d = `DSW_STATUS_RESET;
      status_d[`DSW_BIT_CTRL_READY] = s_ctrl & ~s_trip;
      status_d[`DSW_BIT_DRV_READY] = s_ctrl & s_pwr & ~s_trip & ~s_lock;
      status_d[`DSW_BIT_ENABLE] = ~s_coast & ~s_trip & ~s_lock;
      status_d[`DSW_BIT_TRIP] = s_trip;
      status_d[`DSW_BIT_ERROR] = s_err & ~s_trip;
      status_d[`DSW_BIT_UNUSED] = 1'b0;
      status_d[`DSW_BIT_TRIPLOCK] = s_trip & s_lock;
      status_d[`DSW_BIT_WARNING] = s_warn;
      status_d[`DSW_BIT_ON_REF] = (out_freq == ref_freq);
      status_d[`DSW_BIT_BUS_CTRL] = ~s_local;
      // limits compare signed so reverse running is handled
      status_d[`DSW_BIT_FREQ_OK] = ($signed(out_freq) > $signed(freq_low_limit)) &&
                                   ($signed(out_freq) < $signed(freq_high_limit));
      status_d[`DSW_BIT_RUNNING] = s_start & ~s_coast & ~s_trip & ~s_otemp;
      status_d[`DSW_BIT_AUTO_RESTART] = s_otemp & ~s_trip;
      status_d[`DSW_BIT_VOLTAGE] = s_vlow | s_vhigh;
      status_d[`DSW_BIT_CURRENT] = dsw_above(motor_current, current_limit);
      status_d[`DSW_BIT_TIMER] = dsw_above(motor_thermal_timer, `DSW_TIMER_FULL) ||
                                 dsw_above(drive_thermal_timer, `DSW_TIMER_FULL);
   end

   // status word register, bit 00 in the lsb
   always @(posedge ref_clk) begin
      if (sys_rst)
         drive_status_word <= `DSW_STATUS_RESET;
      else
         drive_status_word <= status_d;
   end

   // frequency word already scaled; registered so output comes from a flop
   always @(posedge ref_clk) begin
      if (sys_rst)
         actual_output_frequency_word <= `DSW_ZERO_WORD;
      else
         actual_output_frequency_word <= mav_word;
   end

   // reference word held as received, two's complement kept as is
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         speed_reference_q <= `DSW_ZERO_WORD;
         speed_reference_pct_q <= `DSW_ZERO_WORD;
      end else if (ref_write) begin
         speed_reference_q <= ref_word_in;
         speed_reference_pct_q <= dsw_to_centi(ref_word_in);
      end
   end
endmodule // dsw_status_top

// File: dsw_sync2.v
// two-flop synchroniser for a bus of asynchronous condition levels
`timescale 1ns/1ps
module dsw_sync2 #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // asynchronous levels in, synchronised levels out
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;

   // first stage is read only by the second stage
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // dsw_sync2

// File: dsw_tb.sv
// self-checking testbench for the drive status and speed words
`timescale 1ns/1ps
module testbench;
   reg ref_clk = 1'b0, sys_rst = 1'b1, send = 1'b0;
   reg [11:0] pin = 12'h02c;
   reg [15:0] of = 16'h1000, fs = 16'h2000, cur = 16'h0000, tm = 16'h0000, wd = 16'h0000, tm2 = 16'h0000;
   wire [15:0] sw, fw, rq, rp, rwd;
   wire rw;
   integer n_fail = 0, total_checks = 0;
   initial forever #20 ref_clk = ~ref_clk;
   dsw_status_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .tripped(pin[0]), .trip_locked(pin[1]),
      .controls_ready(pin[2]), .power_ready(pin[3]), .coast_active(pin[4]), .start_active(pin[5]),
      .error_no_trip(pin[6]), .warning_any(pin[7]), .local_forced(pin[8]), .overtemp_hold(pin[9]),
      .dc_link_low(pin[10]), .dc_link_high(pin[11]), .out_freq(of), .ref_freq(16'h1000),
      .freq_low_limit(16'h0100), .freq_high_limit(16'h3000), .freq_full_scale(fs), .motor_current(cur),
      .current_limit(16'h0100), .motor_thermal_timer(tm), .drive_thermal_timer(tm2), .ref_write(rw),
      .ref_word_in(rwd), .drive_status_word(sw), .actual_output_frequency_word(fw), .speed_reference_q(rq),
      .speed_reference_pct_q(rp));
   dsw_master_model u_master (.ref_clk(ref_clk), .send(send), .word(wd), .ref_write(rw), .ref_word_in(rwd));
   task chk(input [8*6:1] nm, input [15:0] e, input [15:0] g);
      begin
         total_checks = total_checks + 1;
         if (e !== g) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge ref_clk);
   endtask
   // pins pass two sync flops and the status register
   task t_pin(input [11:0] s, input [15:0] m, input [15:0] e);
      begin
         pin = 12'h02c | s;
         cyc(4);
         chk("status", e, sw & m);
      end
   endtask
   task t_pins;
      begin
         t_pin(12'h000, 16'hffff, 16'h0f07);
         t_pin(12'h001, 16'h084f, 16'h0008);
         t_pin(12'h003, 16'h0048, 16'h0048);
         t_pin(12'h040, 16'h0030, 16'h0010);
         t_pin(12'h080, 16'h0080, 16'h0080);
         t_pin(12'h100, 16'h0200, 16'h0000);
         t_pin(12'h200, 16'h1800, 16'h1000);
         t_pin(12'h400, 16'h2000, 16'h2000);
         t_pin(12'h800, 16'h2000, 16'h2000);
         t_pin(12'h010, 16'h0806, 16'h0002);
      end
   endtask
   // a frequency sitting on a limit counts as out of limits; current and timers sitting on a limit are not flagged
   task t_values;
      begin
         of = 16'h3000;
         cur = 16'h0101;
         tm = 16'h4001;
         cyc(4);
         chk("limits", 16'hc000, sw & 16'hc500);
         chk("freq", 16'h6000, fw);
         of = 16'hf000;
         cur = 16'h0100;
         tm = 16'h4000;
         cyc(4);
         chk("bounds", 16'h0000, sw & 16'hc400);
         chk("freq", 16'he000, fw);
         // drive timer alone trips bit 15; zero full scale gives a zero word
         fs = 16'h0000;
         tm2 = 16'h4001;
         cyc(4);
         chk("timer", 16'h8000, sw & 16'h8000);
         chk("freq", 16'h0000, fw);
      end
   endtask
   // back-to-back writes, then idle data must leave the word alone
   task t_ref;
      begin
         @(posedge ref_clk) {send, wd} <= {1'b1, 16'h4000};
         @(posedge ref_clk) wd <= 16'hc000;
         @(negedge ref_clk) chk("pct", 16'h2710, rp);
         @(posedge ref_clk) send <= 1'b0;
         cyc(4);
         chk("ref", 16'hc000, rq);
         chk("pct", 16'hd8f0, rp);
      end
   endtask
   task test_done;
      begin
         $display("checks %0d fails %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      cyc(8);
      chk("reset", 16'h0000, sw);
      chk("freq", 16'h0000, fw);
      sys_rst = 1'b0;
      t_pins;
      t_values;
      t_ref;
      test_done;
   end
   initial begin
      #20000;
      n_fail = n_fail + 1;
      test_done;
   end
endmodule // testbench
